// [arp_ctrl.sv]
`timescale 1ns/1ps
// Purpose: Reference selection, power state and result memory control
// Assumes: Bus master on scl/sda; analog core on the system clock
// Notes: Link watcher runs on link_clk_i and hands events over by toggles
module arp_ctrl #(
  parameter int REF_WAKE_CYC = arp_pkg::REF_WAKE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic conv_start_o,
  output logic [3:0] conv_chan_o,
  output logic conv_single_o,
  output logic conv_pin_gnd_o,
  input wire logic adc_done_i,
  input wire logic [10:0] adc_fine_i,
  output logic analog_en_o,
  output logic ref_power_o,
  output logic ref_internal_o,
  output logic ref_buf_oe_o,
  output logic pin_ref_mode_o
);

  // ***********************************************************************
  // Link domain: START/STOP and address watcher
  // ***********************************************************************
  logic lrst_s1_r;
  logic lrst_b_r;
  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_d_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_d_r;
  logic hunt_r, hunt_nxt;
  logic busy_r, busy_nxt;
  logic rd_r, rd_nxt;
  logic ack_pend_r, ack_pend_nxt;
  logic ack_r, ack_nxt;
  logic [3:0] bits_r, bits_nxt;
  logic [6:0] sh_r, sh_nxt;
  logic addr_tgl_r, addr_tgl_nxt;
  logic end_tgl_r, end_tgl_nxt;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  always_ff @(posedge link_clk_i) begin
    lrst_s1_r <= rst_b_i;
    lrst_b_r <= lrst_s1_r;
    scl_s1_r <= scl_i;
    scl_s2_r <= scl_s1_r;
    scl_d_r <= scl_s2_r;
    sda_s1_r <= sda_i;
    sda_s2_r <= sda_s1_r;
    sda_d_r <= sda_s2_r;
  end

  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;

  always_comb begin
    hunt_nxt = hunt_r;
    busy_nxt = busy_r;
    rd_nxt = rd_r;
    ack_pend_nxt = ack_pend_r;
    ack_nxt = ack_r;
    bits_nxt = bits_r;
    sh_nxt = sh_r;
    addr_tgl_nxt = addr_tgl_r;
    end_tgl_nxt = end_tgl_r;
    if (start_det) begin
      // A repeated START ends the transaction in progress
      if (busy_r) begin
        end_tgl_nxt = ~end_tgl_r;
      end
      hunt_nxt = 1'b1;
      busy_nxt = 1'b0;
      bits_nxt = 4'h0;
      ack_pend_nxt = 1'b0;
    end else if (stop_det) begin
      if (busy_r) begin
        end_tgl_nxt = ~end_tgl_r;
      end
      hunt_nxt = 1'b0;
      busy_nxt = 1'b0;
      ack_pend_nxt = 1'b0;
    end else if (scl_rise && (hunt_r || busy_r)) begin
      bits_nxt = (bits_r == 4'h8) ? 4'h0 : bits_r + 4'h1;
      if (hunt_r) begin
        sh_nxt = {sh_r[5:0], sda_s2_r};
        if (bits_r == 4'h7) begin
          // Foreign addresses drop the watcher back to waiting for START
          hunt_nxt = 1'b0;
          if (sh_r == arp_pkg::OWN_ADDR) begin
            busy_nxt = 1'b1;
            rd_nxt = sda_s2_r;
            ack_pend_nxt = 1'b1;
            addr_tgl_nxt = ~addr_tgl_r;
          end
        end
      end else if (rd_r && bits_r == 4'h8 && sda_s2_r) begin
        busy_nxt = 1'b0;
        end_tgl_nxt = ~end_tgl_r;
      end
    end else if (scl_fall) begin
      ack_nxt = ack_pend_r;
      ack_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!lrst_b_r) begin
      hunt_r <= 1'b0;
      busy_r <= 1'b0;
      rd_r <= 1'b0;
      ack_pend_r <= 1'b0;
      ack_r <= 1'b0;
      bits_r <= 4'h0;
      sh_r <= 7'h00;
      addr_tgl_r <= 1'b0;
      end_tgl_r <= 1'b0;
    end else begin
      hunt_r <= hunt_nxt;
      busy_r <= busy_nxt;
      rd_r <= rd_nxt;
      ack_pend_r <= ack_pend_nxt;
      ack_r <= ack_nxt;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      addr_tgl_r <= addr_tgl_nxt;
      end_tgl_r <= end_tgl_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = ack_r;

  // ***********************************************************************
  // Event crossing into the system domain
  // ***********************************************************************
  logic addr_evt;
  logic end_evt;

  arp_tgl_sync u_addr_sync (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .tgl_i(addr_tgl_r),
    .pulse_o(addr_evt)
  );

  arp_tgl_sync u_end_sync (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .tgl_i(end_tgl_r),
    .pulse_o(end_evt)
  );

  // ***********************************************************************
  // Configuration and reference control
  // ***********************************************************************
  logic [11:0] ctrl_r, ctrl_nxt;
  logic [2:0] sel;
  logic ext_clk;
  logic [1:0] scan;
  logic [3:0] cs;
  logic pin_ref;
  logic ref_on;
  logic ref_ready;
  logic [20:0] ref_cnt_r, ref_cnt_nxt;
  logic ctrl_wr;
  arp_pkg::arp_state_t st_r, st_nxt;

  assign sel = ctrl_r[arp_pkg::SEL_LSB +: 3];
  assign ext_clk = ctrl_r[arp_pkg::EXT_CLK_BIT];
  assign scan = ctrl_r[arp_pkg::SCAN_LSB +: 2];
  assign cs = ctrl_r[arp_pkg::CS_LSB +: 4];
  assign pin_ref = sel[1];
  // Keep-on follows the stored field, so it lasts until software rewrites it
  assign ref_on = sel[2] & (sel[0] | (st_r != arp_pkg::ST_SHDN));
  assign ref_ready = (ref_cnt_r == 21'(REF_WAKE_CYC));

  assign ctrl_wr = psel_i & penable_i & pwrite_i &
                   (paddr_i == arp_pkg::OFS_CTRL);

  always_comb begin
    ctrl_nxt = ctrl_wr ? pwdata_i[11:0] : ctrl_r;
    // Wake timer restarts whenever the reference loses power
    if (!ref_on) begin
      ref_cnt_nxt = 21'h000000;
    end else if (!ref_ready) begin
      ref_cnt_nxt = ref_cnt_r + 21'h000001;
    end else begin
      ref_cnt_nxt = ref_cnt_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= arp_pkg::CTRL_RST;
      ref_cnt_r <= 21'h000000;
    end else begin
      ctrl_r <= ctrl_nxt;
      ref_cnt_r <= ref_cnt_nxt;
    end
  end

  assign ref_power_o = ref_on;
  assign ref_internal_o = sel[2];
  assign pin_ref_mode_o = pin_ref;
  assign ref_buf_oe_o = sel[2] & sel[1] & (st_r != arp_pkg::ST_SHDN);
  assign analog_en_o = (st_r != arp_pkg::ST_SHDN);

  // ***********************************************************************
  // Scan sequencing and power state
  // ***********************************************************************
  function automatic logic [3:0] arp_first(input logic [1:0] md,
                                           input logic [3:0] c);
    logic [3:0] f;
    f = c;
    if (md == arp_pkg::SCAN_UP) begin
      f = 4'h0;
    end else if (md == arp_pkg::SCAN_UPPER) begin
      f = arp_pkg::UPPER_FIRST;
    end
    return f;
  endfunction : arp_first

  function automatic logic [3:0] arp_last(input logic [1:0] md,
                                          input logic [3:0] c,
                                          input logic pr);
    logic [3:0] l;
    l = (c > arp_pkg::PIN_CH) ? arp_pkg::PIN_CH : c;
    if (md == arp_pkg::SCAN_UPPER && l < arp_pkg::UPPER_FIRST) begin
      l = arp_pkg::UPPER_FIRST;
    end
    // Reference pin is never converted single-ended in an up or upper scan
    if ((md == arp_pkg::SCAN_UP || md == arp_pkg::SCAN_UPPER) && pr &&
        l > arp_pkg::REF_LIMIT) begin
      l = arp_pkg::REF_LIMIT;
    end
    return l;
  endfunction : arp_last

  logic [3:0] chan_r, chan_nxt;
  logic [3:0] last_r, last_nxt;
  logic [3:0] rep_r, rep_nxt;
  logic [3:0] widx_r, widx_nxt;
  logic [3:0] res_cnt_r, res_cnt_nxt;
  logic mem_we;
  logic seq_end;
  logic [9:0] mem_r [arp_pkg::RES_WORDS];
  arp_fmt_if fmt_bus ();

  assign fmt_bus.fine = adc_fine_i;
  assign fmt_bus.bipolar = ctrl_r[arp_pkg::BIP_BIT];

  arp_fmt u_fmt (
    .f(fmt_bus)
  );

  assign seq_end = (chan_r == last_r) && (rep_r == 4'h1);

  always_comb begin
    st_nxt = st_r;
    chan_nxt = chan_r;
    last_nxt = last_r;
    rep_nxt = rep_r;
    widx_nxt = widx_r;
    res_cnt_nxt = res_cnt_r;
    mem_we = 1'b0;
    if (end_evt) begin
      // Held results are given up at STOP or repeated START
      res_cnt_nxt = 4'h0;
    end
    unique case (st_r)
      arp_pkg::ST_SHDN: begin
        if (addr_evt) begin
          chan_nxt = arp_first(scan, cs);
          last_nxt = arp_last(scan, cs, pin_ref);
          rep_nxt = (scan == arp_pkg::SCAN_REPEAT) ? arp_pkg::REPEAT_CNT :
                    4'h1;
          widx_nxt = 4'h0;
          res_cnt_nxt = 4'h0;
          // No wait at all unless the internal reference is in use
          st_nxt = sel[2] ? arp_pkg::ST_WAKE : arp_pkg::ST_ISSUE;
        end
      end
      arp_pkg::ST_WAKE: begin
        if (ref_ready) begin
          st_nxt = arp_pkg::ST_ISSUE;
        end
      end
      arp_pkg::ST_ISSUE: begin
        st_nxt = arp_pkg::ST_WAIT;
      end
      arp_pkg::ST_WAIT: begin
        if (adc_done_i) begin
          mem_we = (widx_r < 4'(arp_pkg::RES_WORDS));
          widx_nxt = mem_we ? widx_r + 4'h1 : widx_r;
          res_cnt_nxt = mem_we ? widx_r + 4'h1 : res_cnt_r;
          if (rep_r != 4'h1) begin
            rep_nxt = rep_r - 4'h1;
          end else begin
            chan_nxt = chan_r + 4'h1;
          end
          if (!seq_end) begin
            st_nxt = arp_pkg::ST_ISSUE;
          end else if (ext_clk) begin
            st_nxt = arp_pkg::ST_LOOP;
          end else begin
            st_nxt = arp_pkg::ST_SHDN;
          end
        end
      end
      arp_pkg::ST_LOOP: begin
        // External clock mode converts on until the master lets go
        chan_nxt = arp_first(scan, cs);
        rep_nxt = (scan == arp_pkg::SCAN_REPEAT) ? arp_pkg::REPEAT_CNT :
                  4'h1;
        widx_nxt = 4'h0;
        st_nxt = arp_pkg::ST_ISSUE;
      end
      default: begin
        st_nxt = arp_pkg::ST_SHDN;
      end
    endcase
    if (end_evt && ext_clk && st_r != arp_pkg::ST_SHDN) begin
      st_nxt = arp_pkg::ST_SHDN;
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_r <= arp_pkg::ST_SHDN;
      chan_r <= 4'h0;
      last_r <= 4'h0;
      rep_r <= 4'h1;
      widx_r <= 4'h0;
      res_cnt_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      chan_r <= chan_nxt;
      last_r <= last_nxt;
      rep_r <= rep_nxt;
      widx_r <= widx_nxt;
      res_cnt_r <= res_cnt_nxt;
    end
  end

  // Memory is left unset at reset; contents are undefined until written
  always_ff @(posedge sys_clk_i) begin
    if (mem_we) begin
      mem_r[widx_r] <= fmt_bus.code;
    end
  end

  assign conv_start_o = (st_r == arp_pkg::ST_ISSUE);
  assign conv_chan_o = chan_r;
  assign conv_single_o = ctrl_r[arp_pkg::SGL_BIT];
  // Pairs holding the shared pin see it as ground
  assign conv_pin_gnd_o = ~ctrl_r[arp_pkg::SGL_BIT] & pin_ref &
                          ((chan_r | 4'h1) == arp_pkg::PIN_CH);

  // ***********************************************************************
  // APB slave
  // ***********************************************************************
  logic [31:0] rdata_r, rdata_nxt;
  logic err_r, err_nxt;
  logic [11:0] res_ofs;
  logic [3:0] res_idx;

  assign res_ofs = paddr_i - arp_pkg::OFS_RES_BASE;
  assign res_idx = res_ofs[5:2];

  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    // Answer is prepared in the setup cycle, so access needs no wait state
    if (psel_i && !penable_i) begin
      rdata_nxt = 32'h00000000;
      err_nxt = 1'b0;
      if (paddr_i == arp_pkg::OFS_CTRL) begin
        rdata_nxt = {20'h00000, ctrl_r};
      end else if (paddr_i == arp_pkg::OFS_STATUS) begin
        rdata_nxt = {20'h00000, res_cnt_r, ref_ready, ref_on, pin_ref,
                     st_r};
      end else if (paddr_i >= arp_pkg::OFS_RES_BASE &&
                   paddr_i <= arp_pkg::OFS_RES_LAST &&
                   paddr_i[1:0] == 2'h0) begin
        rdata_nxt = {22'h000000, mem_r[res_idx]};
      end else begin
        err_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign pready_o = 1'b1;
  assign prdata_o = rdata_r;
  assign pslverr_o = err_r & psel_i & penable_i;

endmodule : arp_ctrl

// [arp_pkg.sv]
// Purpose: Constants, register map and types of the reference/power control
// Assumes: 100 MHz system clock, APB register access, 12 input channels
// Notes: Shared pin is the highest channel; result memory holds 12 words

package arp_pkg;

  // ***********************************************************************
  // Register map
  // ***********************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_RES_BASE = 12'h040;
  localparam logic [11:0] OFS_RES_LAST = 12'h06c;
  localparam int RES_WORDS = 12;
  localparam int SEL_LSB = 0;
  localparam int EXT_CLK_BIT = 3;
  localparam int SCAN_LSB = 4;
  localparam int CS_LSB = 6;
  localparam int SGL_BIT = 10;
  localparam int BIP_BIT = 11;
  localparam logic [11:0] CTRL_RST = 12'h400;

  // ***********************************************************************
  // Channels, codes and timing
  // ***********************************************************************
  localparam logic [3:0] PIN_CH = 4'hb;
  localparam logic [3:0] REF_LIMIT = 4'ha;
  localparam logic [3:0] UPPER_FIRST = 4'h6;
  localparam logic [3:0] REPEAT_CNT = 4'h8;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam logic [9:0] BIP_FLIP = 10'h200;
  localparam logic [1:0] SCAN_UP = 2'h0;
  localparam logic [1:0] SCAN_REPEAT = 2'h1;
  localparam logic [1:0] SCAN_UPPER = 2'h2;
  localparam int REF_WAKE_MS = 10;
  localparam int CLK_MHZ = 100;
  localparam int REF_WAKE_CYC = REF_WAKE_MS * 1000 * CLK_MHZ;
  // Value is arbitrary
  localparam logic [6:0] OWN_ADDR = 7'h33;

  typedef enum logic [4:0] {
    ST_SHDN = 5'h01,
    ST_WAKE = 5'h02,
    ST_ISSUE = 5'h04,
    ST_WAIT = 5'h08,
    ST_LOOP = 5'h10
  } arp_state_t;

endpackage : arp_pkg

// [arp_fmt_if.sv]
`timescale 1ns/1ps
// Purpose: Carries raw samples to the result formatter and codes back
// Assumes: Same clock domain on both sides
// Notes: Purely combinational path
interface arp_fmt_if;
  logic [10:0] fine;
  logic bipolar;
  logic [9:0] code;
  modport core (output fine, output bipolar, input code);
  modport fmt (input fine, input bipolar, output code);
endinterface : arp_fmt_if

// [arp_tgl_sync.sv]
`timescale 1ns/1ps
// Purpose: Carries a toggle event from the link domain as a one-cycle pulse
// Assumes: Source toggles at most once per several destination cycles
// Notes: First stage feeds only the second stage
module arp_tgl_sync (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tgl_i,
  output logic pulse_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= tgl_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign pulse_o = s2_r ^ s3_r;
endmodule : arp_tgl_sync

// [arp_fmt.sv]
`timescale 1ns/1ps
// Purpose: Turns half-step samples into 10-bit output codes
// Assumes: Sample is in units of half a step above the range bottom
// Notes: Saturates at full scale
module arp_fmt (
  arp_fmt_if.fmt f
);
  logic [11:0] sum;
  logic [9:0] bin;

  always_comb begin
    // Adding half a step puts each transition midway between steps
    sum = {1'b0, f.fine} + 12'h001;
    bin = sum[11] ? arp_pkg::CODE_MAX : sum[10:1];
    f.code = f.bipolar ? (bin ^ arp_pkg::BIP_FLIP) : bin;
  end
endmodule : arp_fmt

// [arp_ctrl_properties.sv]
// Purpose: Concurrent checks on the reference and power outputs
// Assumes: Single system clock domain, synchronous active-low reset
// Notes: Bound into every arp_ctrl instance
`timescale 1ns/1ps
module arp_ctrl_properties #(
  parameter int REF_WAKE_CYC = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic conv_start_o,
  input wire logic [3:0] conv_chan_o,
  input wire logic conv_single_o,
  input wire logic conv_pin_gnd_o,
  input wire logic analog_en_o,
  input wire logic ref_power_o,
  input wire logic ref_internal_o,
  input wire logic ref_buf_oe_o,
  input wire logic pin_ref_mode_o
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Eight quiet cycles is a floor well below any real wake count
  sequence s_cold_wake;
    $rose(analog_en_o) && ref_internal_o && !$past(ref_power_o);
  endsequence
  sequence s_no_request;
    !conv_start_o [*8];
  endsequence

  a_wake_delay: assert property (s_cold_wake |-> s_no_request)
    else $error("conversion requested before reference wake");
  a_no_wake: assert property ($rose(analog_en_o) && !ref_internal_o
    |-> conv_start_o) else $error("wake delay seen with supply ref");
  a_buf_drive: assert property (ref_buf_oe_o ==
    (ref_internal_o && pin_ref_mode_o && analog_en_o))
    else $error("reference buffer enable wrong");
  a_ref_off: assert property (!ref_internal_o |-> !ref_power_o)
    else $error("internal reference powered while unselected");
  a_keep_on: assert property (ref_power_o && !analog_en_o &&
    !(psel_i && penable_i && pwrite_i && paddr_i == 12'h000)
    |=> ref_power_o) else $error("kept reference dropped");
  a_pin_ground: assert property (conv_start_o |-> conv_pin_gnd_o ==
    (!conv_single_o && pin_ref_mode_o && conv_chan_o >= 4'ha))
    else $error("pin ground flag wrong");
  a_scan_cap: assert property (conv_start_o && pin_ref_mode_o &&
    conv_single_o |-> conv_chan_o <= 4'ha)
    else $error("reference pin converted single-ended");
  a_shdn_quiet: assert property (!analog_en_o |->
    !conv_start_o && !ref_buf_oe_o) else $error("activity in shutdown");
  a_reset_cfg: assert property ($rose(rst_b_i) |-> conv_single_o &&
    !pin_ref_mode_o && !analog_en_o && !ref_power_o)
    else $error("power-on configuration wrong");
endmodule : arp_ctrl_properties

bind arp_ctrl arp_ctrl_properties #(.REF_WAKE_CYC(REF_WAKE_CYC)) u_props (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
  .conv_single_o(conv_single_o), .conv_pin_gnd_o(conv_pin_gnd_o),
  .analog_en_o(analog_en_o), .ref_power_o(ref_power_o),
  .ref_internal_o(ref_internal_o), .ref_buf_oe_o(ref_buf_oe_o),
  .pin_ref_mode_o(pin_ref_mode_o));

// [arp_i2c_master.sv]
// Purpose: Behavioural two-wire bus master for address frames
// Assumes: SDA is open drain with a pull-up, resolved by the bench
// Notes: SCL stands still between calls; SDA moves only while SCL is low, except at START and STOP
`timescale 1ns/1ps
module arp_i2c_master #(
  parameter int HALF = 8
) (
  input wire logic link_clk_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic half_bit;
    repeat (HALF) @(posedge link_clk_i);
  endtask : half_bit

  // ************************************************************
  // START or repeated START, one byte, then the acknowledge slot
  // ************************************************************
  task automatic frame(input logic [7:0] b, output logic ack);
    @(posedge link_clk_i);
    if (scl_o === 1'b0) begin
      sda_o <= 1'b1;
      half_bit();
      scl_o <= 1'b1;
      half_bit();
    end
    sda_o <= 1'b0;
    half_bit();
    for (int i = 7; i >= 0; i--) begin
      scl_o <= 1'b0;
      half_bit();
      sda_o <= b[i];
      half_bit();
      scl_o <= 1'b1;
      half_bit();
    end
    scl_o <= 1'b0;
    half_bit();
    sda_o <= 1'b1;
    half_bit();
    scl_o <= 1'b1;
    half_bit();
    ack = sda_line_i;
    scl_o <= 1'b0;
    half_bit();
  endtask : frame

  task automatic stop;
    @(posedge link_clk_i);
    sda_o <= 1'b0;
    half_bit();
    scl_o <= 1'b1;
    half_bit();
    sda_o <= 1'b1;
    half_bit();
  endtask : stop
endmodule : arp_i2c_master

// [testbench.sv]
// Purpose: Self-checking bench for reference, power and result memory
// Assumes: Wake count shortened to 20 cycles
// Notes: Reads are noted in a queue and checked by a monitor process
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, scl, sda_m, sda_oe;
  logic sda_dev, ext_ack;
  logic conv_start, conv_single, conv_pin_gnd, analog_en, ref_power;
  logic ref_internal, ref_buf_oe, pin_ref, cur_bip, adc_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] conv_chan;
  logic [10:0] adc_fine, fine;
  logic [2:0] dly = 3'h0;
  logic [64:0] rd_note;
  logic [64:0] exp_rd[$];
  logic [3:0] exp_ch[$];
  logic [9:0] res_code[$];
  logic [11:0] cases[6] = '{12'h4c0, 12'h6c2, 12'hab7, 12'hc96, 12'h624,
                            12'h4e1};
  int miscompares = 0;
  int samples_checked = 0;
  wire sda_line = sda_m & (sda_dev | ~sda_oe);

  arp_ctrl #(.REF_WAKE_CYC(20)) u_arp_ctrl (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .link_clk_i(link_clk_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_dev), .sda_oe_o(sda_oe),
    .conv_start_o(conv_start), .conv_chan_o(conv_chan),
    .conv_single_o(conv_single), .conv_pin_gnd_o(conv_pin_gnd),
    .adc_done_i(adc_done), .adc_fine_i(adc_fine), .analog_en_o(analog_en),
    .ref_power_o(ref_power), .ref_internal_o(ref_internal),
    .ref_buf_oe_o(ref_buf_oe), .pin_ref_mode_o(pin_ref));
  arp_i2c_master u_arp_i2c_master (.link_clk_i(link_clk_i),
    .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_m));

  initial forever #5 sys_clk_i = ~sys_clk_i;
  initial begin
    #1.7;
    forever #3 link_clk_i = ~link_clk_i;
  end

  // ************************************************************
  // Reporting
  // ************************************************************
  task automatic wrap_up;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic fail_now;
    miscompares++;
    wrap_up();
  endtask : fail_now

  task automatic cmp_rd(input logic [31:0] a, input logic [31:0] e);
    samples_checked++;
    if (a !== e) begin
      miscompares++;
      $display("[FAIL] %0t read %h expected %h", $time, a, e);
    end
  endtask : cmp_rd

  task automatic cmp_ch(input logic [3:0] a, input logic [3:0] e);
    samples_checked++;
    if (a !== e) begin
      miscompares++;
      $display("[FAIL] %0t channel %h expected %h", $time, a, e);
    end
  endtask : cmp_ch

  task automatic cmp_lvl(input logic a, input logic e);
    samples_checked++;
    if (a !== e) begin
      miscompares++;
      $display("[FAIL] %0t level %h expected %h", $time, a, e);
    end
  endtask : cmp_lvl

  // Straight binary from half steps, saturating; bipolar flips the top bit
  function automatic logic [9:0] code_of(input logic [10:0] f,
                                         input logic b);
    logic [11:0] c;
    c = ({1'b0, f} + 12'h001) >> 1;
    if (c > 12'h3ff) c = 12'h3ff;
    return c[9:0] ^ {b, 9'h000};
  endfunction : code_of

  // ************************************************************
  // APB master and read monitor
  // ************************************************************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_rd.push_back({d & m, m, e});
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_now();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge sys_clk_i) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_rd.size() == 0) fail_now();
      rd_note = exp_rd.pop_front();
      cmp_rd(prdata & rd_note[32:1], rd_note[64:33]);
      cmp_lvl(pslverr, rd_note[0]);
    end
  end

  // Converter stand-in: answers each request three cycles later
  always @(posedge sys_clk_i) begin
    adc_done <= (dly == 3'h1);
    if (dly != 3'h0) dly <= dly - 3'h1;
    if (conv_start === 1'b1) begin
      if (exp_ch.size() == 0) fail_now();
      cmp_ch(conv_chan, exp_ch.pop_front());
      fine = 11'($urandom_range(2047));
      adc_fine <= fine;
      dly <= 3'h3;
      res_code.push_back(code_of(fine, cur_bip));
    end
  end

  // ************************************************************
  // One configuration, one request, read back, then end it
  // ************************************************************
  task automatic run_case(input logic [11:0] ctrl, input int i);
    logic [3:0] cs, lo, hi;
    logic ack;
    int n;
    cs = ctrl[9:6];
    lo = (ctrl[5:4] == 2'h2) ? 4'h6 : 4'h0;
    hi = (cs > 4'hb) ? 4'hb : cs;
    if (ctrl[5:4] == 2'h2 && hi < 4'h6) hi = 4'h6;
    if (ctrl[1] && hi > 4'ha) hi = 4'ha;
    if (ctrl[4]) lo = cs;
    if (ctrl[4]) hi = cs;
    for (int c = lo; c <= hi; c++)
      repeat ((ctrl[5:4] == 2'h1) ? 8 : 1) exp_ch.push_back(4'(c));
    n = exp_ch.size();
    res_code.delete();
    cur_bip = ctrl[11];
    apb(1'b1, arp_pkg::OFS_CTRL, {20'h00000, ctrl}, 32'h0, 1'b0);
    u_arp_i2c_master.frame({arp_pkg::OWN_ADDR, 1'b1}, ack);
    cmp_lvl(ack, 1'b0);
    for (int k = 0; k <= 5000; k++) begin
      if (k == 5000) fail_now();
      if (res_code.size() == n && analog_en === 1'b0) break;
      @(posedge sys_clk_i);
    end
    cmp_lvl(pin_ref, ctrl[1]);
    cmp_lvl(ref_power, ctrl[2] & ctrl[0]);
    cmp_lvl(ref_internal, ctrl[2]);
    cmp_lvl(ref_buf_oe, 1'b0);
    apb(1'b0, arp_pkg::OFS_STATUS, {20'h0, 4'(n), 2'h0, ctrl[1], 5'h01},
        32'h00000f3f, 1'b0);
    for (int k = 0; k < n; k++)
      apb(1'b0, arp_pkg::OFS_RES_BASE + 12'(4 * k), {22'h0, res_code[k]},
          32'h000003ff, 1'b0);
    if (i % 2 == 1) begin
      u_arp_i2c_master.frame({arp_pkg::OWN_ADDR ^ 7'h01, 1'b1}, ack);
      cmp_lvl(ack, 1'b1);
      repeat (100) @(posedge sys_clk_i);
      cmp_lvl(analog_en, 1'b0);
    end
    u_arp_i2c_master.stop();
    // Let the end event cross into the system domain first
    repeat (10) @(posedge sys_clk_i);
    apb(1'b0, arp_pkg::OFS_STATUS, 32'h00000001, 32'h00000f1f,
        1'b0);
  endtask : run_case

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    adc_done = 1'b0;
    adc_fine = 11'h000;
    cur_bip = 1'b0;
    void'($urandom(88));
    repeat (4) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge link_clk_i);
    apb(1'b0, arp_pkg::OFS_CTRL, 32'h00000400, 32'h00000fff, 1'b0);
    apb(1'b0, arp_pkg::OFS_STATUS, 32'h00000001, 32'h0000003f,
        1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b0, 12'h041, 32'h0, 32'hffffffff, 1'b1);
    foreach (cases[i]) run_case(cases[i], i);
    // External clock mode loops over channels 0..1 until the master stops
    apb(1'b1, arp_pkg::OFS_CTRL, 32'h00000448, 32'h0, 1'b0);
    repeat (50) begin
      exp_ch.push_back(4'h0);
      exp_ch.push_back(4'h1);
    end
    u_arp_i2c_master.frame({arp_pkg::OWN_ADDR, 1'b1}, ext_ack);
    cmp_lvl(ext_ack, 1'b0);
    repeat (200) @(posedge sys_clk_i);
    cmp_lvl(analog_en, 1'b1);
    u_arp_i2c_master.stop();
    repeat (20) @(posedge sys_clk_i);
    cmp_lvl(analog_en, 1'b0);
    exp_ch.delete();
    wrap_up();
  end
endmodule : testbench
